// ===== rtl/lvd_pkg.sv
package lvd_pkg;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_COUNTER = 2'h2;
  localparam logic [1:0] ADDR_CLKSTOP = 2'h3;
  localparam int BIT_DET_EN = 7;
  localparam int BIT_EXT_DROP_SEL = 5;
  localparam int BIT_EXT_RISE_SEL = 4;
  localparam int BIT_LEVEL_SEL = 3;
  localparam int BIT_RESET_EN = 2;
  localparam int BIT_DROP_IE = 1;
  localparam int BIT_RISE_IE = 0;
  localparam int BIT_REF_STABLE = 7;
  localparam int BIT_VREF_SEL = 3;
  localparam int BIT_DROP_FLAG = 1;
  localparam int BIT_RISE_FLAG = 0;
  localparam int BIT_STANDBY = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] CLKSTOP_RESET = 8'hff;
  localparam logic [7:0] STATUS_WMASK = 8'h7b;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PRESCALE_CYCLES = 131072;
  localparam int NOISE_FILTER_NS = 100;
  localparam int NOISE_FILTER_CYCLES = (NOISE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_DIVIDE = 4;
endpackage : lvd_pkg

// ===== rtl/lvd_pin_filter.sv
`default_nettype none
module lvd_pin_filter
  import lvd_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  output logic pin_o
);
  logic [3:0] count_r;
  logic level_r;
  // Level must hold for the whole window before it is accepted
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count_r <= 4'h0;
      level_r <= 1'b1;
    end else if (pin_i == level_r) begin
      count_r <= 4'h0;
    end else if (count_r == 4'(NOISE_FILTER_CYCLES - 1)) begin
      count_r <= 4'h0;
      level_r <= pin_i;
    end else begin
      count_r <= count_r + 4'h1;
    end
  end
  assign pin_o = level_r;
endmodule : lvd_pin_filter
`default_nettype wire

// ===== rtl/lvd_sync.sv
`default_nettype none
module lvd_sync (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] async_i,
  output logic [2:0] sync_o
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  // Inputs idle high: supply above every level
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_r <= 3'h7;
      sync_r <= 3'h7;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end
  assign sync_o = sync_r;
endmodule : lvd_sync
`default_nettype wire

// ===== rtl/low_voltage_detect_reset_ctrl.sv
`default_nettype none
module low_voltage_detect_reset_ctrl
  import lvd_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic external_reset_pin_n_i,
  input wire logic above_drop_i,
  input wire logic above_rise_i,
  input wire logic above_reset_i,
  input wire logic external_drop_level_in_i,
  input wire logic external_rise_level_in_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic undervoltage_reset_n_o,
  output logic undervoltage_irq_n_o,
  output logic irq_line_zero_o,
  output logic chip_reset_n_o,
  output logic reference_select_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic pin_n;
  logic [2:0] cmp;
  logic [7:0] detector_control_reg_r;
  logic [7:0] detector_status_reg_r;
  logic [7:0] stabilization_counter_r;
  logic [7:0] clock_stop_control_2_r;
  logic [7:0] rdata_r;
  logic [1:0] div_r;
  logic counting_r;
  logic drop_seen_r;
  logic lv_reset_r;
  logic irq_n_r;
  logic irq_r;
  logic rise_read_r;
  logic drop_read_r;
  logic ovf_read_r;
  logic [17:0] prescale_r;
  logic chip_rst_n_r;
  logic active;
  logic above_drop;
  logic above_rise;
  logic above_reset;
  logic tick;
  logic wrap;
  logic drop_evt;
  logic rise_evt;
  logic wr_status;
  logic rd_status;

  lvd_pin_filter u_filter (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(external_reset_pin_n_i),
    .pin_o(pin_n)
  );

  lvd_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({above_drop_i, above_rise_i, above_reset_i}),
    .sync_o(cmp)
  );

  // Enabled and out of module standby
  assign active = detector_control_reg_r[BIT_DET_EN] & clock_stop_control_2_r[BIT_STANDBY];
  assign above_reset = cmp[0];
  assign above_drop = detector_control_reg_r[BIT_EXT_DROP_SEL] ?
                      external_drop_level_in_i : cmp[2];
  assign above_rise = detector_control_reg_r[BIT_EXT_RISE_SEL] ?
                      external_rise_level_in_i : cmp[1];
  assign wr_status = wr_i & (addr_i == ADDR_STATUS);
  assign rd_status = rd_i & (addr_i == ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Control: power-on reset only, low-voltage reset leaves it alone
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      detector_control_reg_r <= CONTROL_RESET;
    end else if (wr_i && addr_i == ADDR_CONTROL) begin
      detector_control_reg_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      clock_stop_control_2_r <= CLKSTOP_RESET;
    end else if (wr_i && addr_i == ADDR_CLKSTOP) begin
      clock_stop_control_2_r <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stabilization counter on a quarter-rate tick
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_r <= 2'h0;
    end else if (counting_r && active) begin
      div_r <= div_r + 2'h1;
    end
  end
  assign tick = counting_r && active && (div_r == 2'(STAB_DIVIDE - 1));
  assign wrap = tick && (stabilization_counter_r == 8'hff);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      counting_r <= 1'b0;
    end else if (wr_i && addr_i == ADDR_CONTROL && wdata_i[BIT_DET_EN]) begin
      counting_r <= 1'b1;
    end else if (wrap) begin
      counting_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !lv_reset_r) begin
      stabilization_counter_r <= COUNTER_RESET;
    end else if (tick) begin
      stabilization_counter_r <= stabilization_counter_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply events; drop remembered until a rise or a reset-level fall
  assign drop_evt = active && !above_drop && !drop_seen_r && above_reset;
  assign rise_evt = active && drop_seen_r && above_rise && above_reset;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !above_reset) begin
      drop_seen_r <= 1'b0;
    end else if (drop_evt) begin
      drop_seen_r <= 1'b1;
    end else if (rise_evt) begin
      drop_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_n_r <= 1'b1;
    end else if (drop_evt) begin
      irq_n_r <= 1'b0;
    end else if (rise_evt) begin
      irq_n_r <= 1'b1;
    end
  end

  // One-cycle request pulse; missing enable means no request
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (drop_evt && detector_control_reg_r[BIT_DROP_IE]) ||
               (rise_evt && detector_control_reg_r[BIT_RISE_IE]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-then-write-0 arming for each flag
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rise_read_r <= 1'b0;
      drop_read_r <= 1'b0;
      ovf_read_r <= 1'b0;
    end else if (rd_status) begin
      rise_read_r <= detector_status_reg_r[BIT_RISE_FLAG];
      drop_read_r <= detector_status_reg_r[BIT_DROP_FLAG];
      ovf_read_r <= detector_status_reg_r[BIT_REF_STABLE];
    end
  end

  // Set wins over a clear in the same cycle; low-voltage reset clears flags
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !lv_reset_r) begin
      detector_status_reg_r <= STATUS_RESET;
    end else begin
      if (wr_status) begin
        detector_status_reg_r[6:3] <= wdata_i[6:3] & STATUS_WMASK[6:3];
        if (!wdata_i[BIT_RISE_FLAG] && rise_read_r) begin
          detector_status_reg_r[BIT_RISE_FLAG] <= 1'b0;
        end
        if (!wdata_i[BIT_DROP_FLAG] && drop_read_r) begin
          detector_status_reg_r[BIT_DROP_FLAG] <= 1'b0;
        end
        if (!wdata_i[BIT_REF_STABLE] && ovf_read_r) begin
          detector_status_reg_r[BIT_REF_STABLE] <= 1'b0;
        end
      end
      if (wrap) begin
        detector_status_reg_r[BIT_REF_STABLE] <= 1'b1;
      end
      if (drop_evt) begin
        detector_status_reg_r[BIT_DROP_FLAG] <= 1'b1;
      end
      if (rise_evt && detector_control_reg_r[BIT_RISE_IE]) begin
        detector_status_reg_r[BIT_RISE_FLAG] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-voltage reset; also taken while only interrupts are in use
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lv_reset_r <= 1'b1;
    end else begin
      lv_reset_r <= !(active && !above_reset &&
                      (detector_control_reg_r[BIT_RESET_EN] ||
                       detector_control_reg_r[BIT_DROP_IE] ||
                       detector_control_reg_r[BIT_RISE_IE]));
    end
  end

  // Prescaler held by pin or low-voltage reset, then counts to release
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !pin_n || !lv_reset_r) begin
      prescale_r <= 18'h00000;
      chip_rst_n_r <= 1'b0;
    end else if (!chip_rst_n_r) begin
      if (prescale_r == 18'(PRESCALE - 1)) begin
        chip_rst_n_r <= 1'b1;
      end else begin
        prescale_r <= prescale_r + 18'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CONTROL: rdata_r <= detector_control_reg_r;
        ADDR_STATUS: rdata_r <= detector_status_reg_r;
        ADDR_COUNTER: rdata_r <= stabilization_counter_r;
        ADDR_CLKSTOP: rdata_r <= clock_stop_control_2_r;
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata_o = rdata_r;
  assign undervoltage_reset_n_o = lv_reset_r;
  assign undervoltage_irq_n_o = irq_n_r;
  assign irq_line_zero_o = irq_r;
  assign chip_reset_n_o = chip_rst_n_r;
  assign reference_select_o = detector_status_reg_r[BIT_VREF_SEL];
endmodule : low_voltage_detect_reset_ctrl
`default_nettype wire

// ===== test/lvd_sva.sv
`default_nettype none
module lvd_sva #(
  parameter int PRESCALE = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic external_reset_pin_n_i,
  input wire logic above_drop_i,
  input wire logic above_rise_i,
  input wire logic above_reset_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic undervoltage_reset_n_o,
  input wire logic undervoltage_irq_n_o,
  input wire logic irq_line_zero_o,
  input wire logic chip_reset_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Sixteen low cycles is well past the glitch filter
  sequence pin_held_low;
    !external_reset_pin_n_i [*8] ##1 !external_reset_pin_n_i [*8];
  endsequence
  sequence supply_fell;
    $fell(undervoltage_reset_n_o);
  endsequence
  a_pin_forces_reset: assert property (pin_held_low |-> ##[0:4] !chip_reset_n_o)
    else $error("held reset pin did not reset chip");
  a_chip_stays_low: assert property (!chip_reset_n_o && !external_reset_pin_n_i |=> !chip_reset_n_o)
    else $error("chip reset released while pin low");
  a_release_after_count: assert property ($rose(chip_reset_n_o) |->
    $past(external_reset_pin_n_i, PRESCALE) && $past(above_reset_i, PRESCALE))
    else $error("chip reset released before prescaler count");
  a_lvr_cause: assert property (supply_fell |-> !$past(above_reset_i))
    else $error("low-voltage reset without low supply");
  a_lvr_holds_chip: assert property (supply_fell |-> ##[0:2] !chip_reset_n_o)
    else $error("low-voltage reset did not hold chip");
  a_drop_cause: assert property ($fell(undervoltage_irq_n_o) |->
    !$past(above_drop_i) && $past(above_reset_i))
    else $error("irq line fell without drop");
  a_rise_cause: assert property ($rose(undervoltage_irq_n_o) |-> $past(above_rise_i))
    else $error("irq line rose without rise");
  a_irq_one_pulse: assert property (irq_line_zero_o |=> !irq_line_zero_o)
    else $error("irq request longer than one cycle");
  a_irq_with_edge: assert property (irq_line_zero_o |-> $changed(undervoltage_irq_n_o))
    else $error("irq request without level change");
  a_read_quiet: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
endmodule : lvd_sva
bind low_voltage_detect_reset_ctrl lvd_sva #(.PRESCALE(PRESCALE)) u_sva (.clk_i, .reset_n_i,
  .external_reset_pin_n_i, .above_drop_i, .above_rise_i, .above_reset_i, .rd_i, .rdata_o,
  .undervoltage_reset_n_o, .undervoltage_irq_n_o, .irq_line_zero_o, .chip_reset_n_o);
`default_nettype wire

// ===== test/low_voltage_detect_reset_ctrl_bench.sv
`default_nettype none
module low_voltage_detect_reset_ctrl_bench import lvd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PS = 16;
  logic clk_i = 0, reset_n_i = 0, pin_n = 1, a_drop = 1, a_rise = 1, a_rst = 1;
  logic wr_i = 0, rd_i = 0, ext_d = 1, ext_u = 1;
  logic [1:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, d;
  logic uv_rst_n, uv_irq_n, irq, chip_n, ref_sel;
  int err_total = 0, n_compared = 0, irqs = 0, cyc = 0, seed = 32'hd844, n, m_st;
  logic [7:0] rst_vals [4] = '{CONTROL_RESET, STATUS_RESET, COUNTER_RESET, CLKSTOP_RESET};
  low_voltage_detect_reset_ctrl #(.PRESCALE(PS)) DUT (.clk_i, .reset_n_i,
    .external_reset_pin_n_i(pin_n), .above_drop_i(a_drop), .above_rise_i(a_rise),
    .above_reset_i(a_rst), .external_drop_level_in_i(ext_d), .external_rise_level_in_i(ext_u),
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .undervoltage_reset_n_o(uv_rst_n),
    .undervoltage_irq_n_o(uv_irq_n), .irq_line_zero_o(irq), .chip_reset_n_o(chip_n),
    .reference_select_o(ref_sel));
  initial forever #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // One-cycle pulses are counted here so a late look cannot miss them
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cycles(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cycles
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rc(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    chk(d, exp, "register read");
  endtask : rc
  task automatic supply(input logic up);
    @(posedge clk_i);
    a_drop <= up;
    a_rise <= up;
  endtask : supply
  task automatic wait_chip(output int c);
    c = 0;
    while (chip_n !== 1'b1 && c < 300) begin
      @(posedge clk_i);
      c++;
    end
  endtask : wait_chip
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cycles(6);
    reset_n_i <= 1'b1;
    wait_chip(n);
    chk(8'(n >= PS && n < PS + 30), 8'h01, "power-on release");
    @(posedge clk_i);
    pin_n <= 1'b0;
    cycles(20);
    chk(8'(chip_n), 8'h00, "pin hold");
    pin_n <= 1'b1;
    wait_chip(n);
    chk(8'(n >= PS && n < PS + 30), 8'h01, "pin release");
    pin_n <= 1'b0;
    cycles(3);
    pin_n <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge clk_i);
      if (chip_n !== 1'b1) n++;
    end
    chk(8'(n), 8'h00, "short pulse");
    for (int a = 0; a < 4; a++) rc(2'(a), rst_vals[a]);
    repeat (4) begin
      m_st = $random(seed) & 8'h78;
      wr(ADDR_STATUS, 8'(m_st));
      rc(ADDR_STATUS, 8'(m_st));
      chk(8'(ref_sel), 8'(m_st[3]), "reference select");
    end
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_COUNTER, 8'($random(seed)));
    rc(ADDR_COUNTER, 8'h00);
    wr(ADDR_CONTROL, 8'h80);
    cycles(40);
    rc(ADDR_COUNTER, 8'h0a);
    chk(8'(d >= 8'h08 && d <= 8'h0c), 8'h01, "counter rate");
    cycles(1000);
    rc(ADDR_STATUS, 8'h80);
    rc(ADDR_COUNTER, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    rc(ADDR_STATUS, 8'h00);
    // Drop with only the drop request enabled, then with both
    for (int ie = 2; ie < 4; ie++) begin
      wr(ADDR_CONTROL, 8'(8'h80 | ie));
      n = irqs;
      supply(1'b0);
      cycles(8);
      chk(8'(uv_irq_n), 8'h00, "drop level");
      chk(8'(irqs - n), 8'h01, "drop request");
      rc(ADDR_STATUS, 8'h02);
      supply(1'b1);
      cycles(8);
      chk(8'(uv_irq_n), 8'h01, "rise level");
      chk(8'(irqs - n), 8'(ie - 1), "rise request");
    end
    wr(ADDR_STATUS, 8'h00);
    rc(ADDR_STATUS, 8'h01);
    wr(ADDR_STATUS, 8'h00);
    rc(ADDR_STATUS, 8'h00);
    wr(ADDR_CLKSTOP, 8'h7f);
    n = irqs;
    supply(1'b0);
    cycles(8);
    chk(8'(uv_irq_n), 8'h01, "standby level");
    chk(8'(irqs - n), 8'h00, "standby request");
    rc(ADDR_STATUS, 8'h00);
    supply(1'b1);
    cycles(8);
    wr(ADDR_CLKSTOP, 8'hff);
    // External levels: internal rise stays high, so only the external rise may end the drop
    wr(ADDR_CONTROL, 8'hb3);
    n = irqs;
    ext_u <= 1'b0;
    @(posedge clk_i);
    ext_d <= 1'b0;
    a_drop <= 1'b0;
    cycles(8);
    chk(8'(uv_irq_n), 8'h00, "external drop level");
    ext_d <= 1'b1;
    a_drop <= 1'b1;
    cycles(8);
    chk(8'(uv_irq_n), 8'h00, "external rise selected");
    ext_u <= 1'b1;
    cycles(8);
    chk(8'(uv_irq_n), 8'h01, "external rise level");
    chk(8'(irqs - n), 8'h02, "external requests");
    rc(ADDR_STATUS, 8'h03);
    wr(ADDR_STATUS, 8'h00);
    rc(ADDR_STATUS, 8'h00);
    // Interrupts alone still give the low-voltage reset
    wr(ADDR_CONTROL, 8'h83);
    @(posedge clk_i);
    a_rst <= 1'b0;
    cycles(8);
    chk(8'(uv_rst_n), 8'h00, "interrupt-mode reset");
    a_rst <= 1'b1;
    wait_chip(n);
    chk(8'(n >= PS && n < PS + 30), 8'h01, "interrupt-mode recovery");
    wr(ADDR_CONTROL, 8'h8c);
    @(posedge clk_i);
    a_rst <= 1'b0;
    cycles(8);
    chk(8'(uv_rst_n), 8'h00, "low-voltage reset");
    chk(8'(chip_n), 8'h00, "low-voltage chip hold");
    a_rst <= 1'b1;
    wait_chip(n);
    chk(8'(n >= PS && n < PS + 30), 8'h01, "recovery count");
    rc(ADDR_CONTROL, 8'h8c);
    wr(ADDR_CONTROL, 8'h88);
    wr(ADDR_CONTROL, 8'h08);
    rc(ADDR_CONTROL, 8'h08);
    wrap_up();
  end
endmodule : low_voltage_detect_reset_ctrl_bench
`default_nettype wire
